// [core/bct_battery_charge_timer.sv]
// Notes on behaviour
// - Closed jumper gives normal charge while adaptor present
// - Power on at connection: eleven hours normal
// - Power off at connection: eight hours normal
// - Trickle falls back to normal at low sample
// - Adaptor removal aborts period; reconnection restarts
// - Every connection starts timer, length from power
// - Aux trickle only when main at threshold
// - Low detect holds aux output low eight hours
// - Adaptor detect high marks connection for timers
// - Low voltage selects auxiliary supply
// - Open aux switch disables aux charge, backup
// - Main output low normal, high trickle
// - Backup select high aux, low main
// - Power off: sample voltage every ten seconds
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "bct_regs.svh"

// Three-stage pin synchroniser; level moves once stages two and three agree
module bct_pin_sync
#(
    parameter int WIDTH = 4
)
(
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Raw and clean levels
    input  wire logic [WIDTH-1:0] pin_raw,
    output logic      [WIDTH-1:0] pin_clean
);
    logic [WIDTH-1:0] s1;   // First stage
    logic [WIDTH-1:0] s2;   // Second stage
    logic [WIDTH-1:0] s3;   // Third stage

    // Shift chain and agreement filter
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1        <= '0;
            s2        <= '0;
            s3        <= '0;
            pin_clean <= '0;
        end
        else
        begin
            s1 <= pin_raw;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < WIDTH; i++)
            begin
                if (s2[i] == s3[i])
                begin
                    pin_clean[i] <= s3[i];
                end
            end
        end
    end
endmodule // bct_pin_sync

module bct_battery_charge_timer
#(
    parameter int          SEC_CYCLES     = `BCT_SEC_CYCLES,
    parameter logic [15:0] ON_SECONDS     = 16'(`BCT_NORMAL_ON_SEC),
    parameter logic [15:0] OFF_SECONDS    = 16'(`BCT_NORMAL_OFF_SEC),
    parameter logic [15:0] AUX_SECONDS    = 16'(`BCT_AUX_SEC),
    parameter logic [3:0]  SAMPLE_OFF_SEC = 4'(`BCT_SAMPLE_OFF_SEC)
)
(
    // Clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // Register bus
    input  wire bct_pkg::bct_axi_req_type axi_req,
    output bct_pkg::bct_axi_rsp_type      axi_rsp,
    // Board pins, asynchronous
    input  wire bct_pkg::bct_pins_type    pins,
    // Voltage converter results, same clock
    input  wire logic [7:0]               batt_code,
    input  wire logic                     batt_code_valid,
    output logic                          sample_request,
    // Charge and supply controls
    output logic                          main_charge_mode_out,
    output logic                          aux_charge_mode_out,
    output logic                          aux_trickle_enable,
    output logic                          backup_source_select
);
    import bct_pkg::*;

    bct_pins_type pin_s;           // Synchronised pins
    logic         adp_d;           // Adaptor level, one cycle late
    logic         conn_event;      // Adaptor connection
    logic [23:0]  prescale;        // Cycle counter for seconds
    logic         sec_tick;        // One pulse per second
    logic [15:0]  main_timer;      // Seconds of normal charge left
    logic [15:0]  aux_timer;       // Seconds of aux normal charge left
    logic [3:0]   sample_cnt;      // Seconds since last sample
    logic [7:0]   last_code;       // Latest converter code
    logic         low5;            // Latest sample at normal threshold
    logic         low_event;       // Sample at low-voltage threshold
    logic [31:0]  ctrl;            // Control register
    logic [7:0]   thr_normal;      // Return-to-normal code
    logic [7:0]   thr_low;         // Supply switch code
    logic         backup_clr;      // Software clear of backup select
    logic         next_main;       // Next main charge mode

    // Input synchroniser
    bct_pin_sync #(.WIDTH(4)) u_sync
    (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .pin_raw   (pins),
        .pin_clean (pin_s)
    );

    // Connection edge on the clean adaptor level
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            adp_d <= 1'b0;
        end
        else
        begin
            adp_d <= pin_s.adaptor_detect_in;
        end
    end
    assign conn_event = pin_s.adaptor_detect_in && !adp_d;

    // Second prescaler, restarted at each connection so a period spans whole seconds
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            prescale <= '0;
            sec_tick <= 1'b0;
        end
        else if (conn_event)
        begin
            prescale <= '0;
            sec_tick <= 1'b0;
        end
        else if (prescale == 24'(SEC_CYCLES - 1))
        begin
            prescale <= '0;
            sec_tick <= 1'b1;
        end
        else
        begin
            prescale <= prescale + 24'h1;
            sec_tick <= 1'b0;
        end
    end

    // Normal charge period timer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            main_timer <= '0;
        end
        else if (!pin_s.adaptor_detect_in)
        begin
            main_timer <= '0;
        end
        else if (conn_event)
        begin
            // Length chosen by power state at connection
            main_timer <= pin_s.power_on ? ON_SECONDS : OFF_SECONDS;
        end
        else if (sec_tick && main_timer != '0)
        begin
            main_timer <= main_timer - 16'h1;
        end
    end

    // Voltage sample capture
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            last_code <= 8'hff;
            low5      <= 1'b0;
        end
        else if (batt_code_valid)
        begin
            last_code <= batt_code;
            low5      <= batt_code <= thr_normal;
        end
    end
    assign low_event = batt_code_valid && (batt_code <= thr_low);

    // Sample requests: each second when on, every ten when off
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sample_cnt     <= '0;
            sample_request <= 1'b0;
        end
        else if (sec_tick)
        begin
            if (pin_s.power_on || sample_cnt >= SAMPLE_OFF_SEC - 4'h1)
            begin
                sample_cnt     <= '0;
                sample_request <= 1'b1;
            end
            else
            begin
                sample_cnt     <= sample_cnt + 4'h1;
                sample_request <= 1'b0;
            end
        end
        else
        begin
            sample_request <= 1'b0;
        end
    end

    // Main charge mode selection
    always_comb
    begin
        if (!pin_s.adaptor_detect_in)
        begin
            next_main = 1'b1;                                  // Nothing to charge
        end
        else if (pin_s.charge_control_jumper)
        begin
            next_main = 1'b0;
        end
        else if (main_timer != '0)
        begin
            next_main = 1'b0;
        end
        else if (ctrl[`BCT_CTRL_FALLBACK] && low5)
        begin
            next_main = 1'b0;
        end
        else
        begin
            next_main = 1'b1;
        end
    end

    // Main output flop
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            main_charge_mode_out <= 1'b1;
        end
        else
        begin
            main_charge_mode_out <= next_main;
        end
    end

    // Auxiliary charge timer and outputs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aux_timer           <= '0;
            aux_charge_mode_out <= 1'b1;
            aux_trickle_enable  <= 1'b0;
        end
        else
        begin
            if (!pin_s.aux_backup_switch)
            begin
                aux_timer <= '0;
            end
            else if (low_event)
            begin
                aux_timer <= AUX_SECONDS;
            end
            else if (sec_tick && aux_timer != '0)
            begin
                aux_timer <= aux_timer - 16'h1;
            end
            aux_charge_mode_out <= !(pin_s.aux_backup_switch && aux_timer != '0);
            aux_trickle_enable  <= pin_s.adaptor_detect_in && pin_s.aux_backup_switch && low5;
        end
    end

    // Backup source select; set beats software clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            backup_source_select <= 1'b0;
        end
        else if (!pin_s.aux_backup_switch)
        begin
            backup_source_select <= 1'b0;
        end
        else if (low_event)
        begin
            backup_source_select <= 1'b1;
        end
        else if (backup_clr)
        begin
            backup_source_select <= 1'b0;
        end
    end

    // AXI4-Lite slave
    logic        aw_got;      // Write address held
    logic        w_got;       // Write data held
    logic [7:0]  aw_addr;     // Held write address
    logic [31:0] w_data;      // Held write data
    logic [3:0]  w_strb;      // Held strobes
    logic        aw_fire;     // Address handshake
    logic        w_fire;      // Data handshake
    logic        do_write;    // Both halves present
    logic [7:0]  wr_addr;     // Effective write address
    logic [31:0] wr_data;     // Effective write data
    logic [3:0]  wr_strb;     // Effective strobes
    logic        wr_ok;       // Address mapped
    logic [31:0] rd_data;     // Read mux
    logic        rd_ok;       // Read address mapped

    assign aw_fire  = axi_req.awvalid && axi_rsp.awready;
    assign w_fire   = axi_req.wvalid && axi_rsp.wready;
    assign do_write = (aw_got || aw_fire) && (w_got || w_fire) && !axi_rsp.bvalid;
    assign wr_addr  = aw_got ? aw_addr : axi_req.awaddr;
    assign wr_data  = w_got ? w_data : axi_req.wdata;
    assign wr_strb  = w_got ? w_strb : axi_req.wstrb;
    assign wr_ok    = wr_addr == `BCT_CTRL_OFS || wr_addr == `BCT_THRESH_OFS;
    assign backup_clr = do_write && wr_ok && wr_addr == `BCT_CTRL_OFS && wr_strb[0]
                        && wr_data[`BCT_CTRL_BACKUP_CLR];

    // Write channels and response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got          <= 1'b0;
            w_got           <= 1'b0;
            aw_addr         <= '0;
            w_data          <= '0;
            w_strb          <= '0;
            axi_rsp.awready <= 1'b0;
            axi_rsp.wready  <= 1'b0;
            axi_rsp.bvalid  <= 1'b0;
            axi_rsp.bresp   <= 2'h0;
        end
        else if (do_write)
        begin
            aw_got          <= 1'b0;
            w_got           <= 1'b0;
            axi_rsp.awready <= 1'b0;
            axi_rsp.wready  <= 1'b0;
            axi_rsp.bvalid  <= 1'b1;
            axi_rsp.bresp   <= wr_ok ? 2'h0 : 2'h2;            // Unmapped: slave error
        end
        else if (axi_rsp.bvalid)
        begin
            if (axi_req.bready)
            begin
                axi_rsp.bvalid  <= 1'b0;
                axi_rsp.awready <= 1'b1;
                axi_rsp.wready  <= 1'b1;
            end
        end
        else
        begin
            if (aw_fire)
            begin
                aw_got  <= 1'b1;
                aw_addr <= axi_req.awaddr;
            end
            if (w_fire)
            begin
                w_got  <= 1'b1;
                w_data <= axi_req.wdata;
                w_strb <= axi_req.wstrb;
            end
            axi_rsp.awready <= !(aw_got || aw_fire);
            axi_rsp.wready  <= !(w_got || w_fire);
        end
    end

    // Writable registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl       <= `BCT_CTRL_RESET;
            thr_normal <= `BCT_THR_NORMAL_CODE;
            thr_low    <= `BCT_THR_LOW_CODE;
        end
        else if (do_write && wr_addr == `BCT_CTRL_OFS && wr_strb[0])
        begin
            ctrl <= {30'h0, wr_data[`BCT_CTRL_FALLBACK], 1'b0}; // Clear bit is a pulse
        end
        else if (do_write && wr_addr == `BCT_THRESH_OFS)
        begin
            if (wr_strb[0])
            begin
                thr_normal <= wr_data[`BCT_THR_NORMAL_LSB +: 8];
            end
            if (wr_strb[1])
            begin
                thr_low <= wr_data[`BCT_THR_LOW_LSB +: 8];
            end
        end
    end

    // Read mux
    always_comb
    begin
        rd_ok = 1'b1;
        case (axi_req.araddr)
            `BCT_CTRL_OFS:   rd_data = ctrl;
            `BCT_THRESH_OFS: rd_data = {16'h0, thr_low, thr_normal};
            `BCT_STATUS_OFS: rd_data = {23'h0, low5, aux_trickle_enable, backup_source_select,
                                        aux_charge_mode_out, main_charge_mode_out, pin_s};
            `BCT_TIMER_OFS:  rd_data = {aux_timer, main_timer};
            `BCT_SAMPLE_OFS: rd_data = {24'h0, last_code};
            default:
            begin
                rd_data = '0;
                rd_ok   = 1'b0;
            end
        endcase
    end

    // Read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            axi_rsp.arready <= 1'b0;
            axi_rsp.rvalid  <= 1'b0;
            axi_rsp.rdata   <= '0;
            axi_rsp.rresp   <= 2'h0;
        end
        else if (axi_rsp.rvalid)
        begin
            if (axi_req.rready)
            begin
                axi_rsp.rvalid  <= 1'b0;
                axi_rsp.arready <= 1'b1;
            end
        end
        else if (axi_req.arvalid && axi_rsp.arready)
        begin
            axi_rsp.arready <= 1'b0;
            axi_rsp.rvalid  <= 1'b1;
            axi_rsp.rdata   <= rd_data;
            axi_rsp.rresp   <= rd_ok ? 2'h0 : 2'h2;
        end
        else
        begin
            axi_rsp.arready <= 1'b1;
        end
    end

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_jumper_normal;
        pin_s.charge_control_jumper && pin_s.adaptor_detect_in |=> !main_charge_mode_out;
    endproperty
    a_jumper_normal: assert property (p_jumper_normal) else $error("jumper bypass failed");

    property p_on_period;
        conn_event && pin_s.power_on |=> main_timer == ON_SECONDS ##1 !main_charge_mode_out;
    endproperty
    a_on_period: assert property (p_on_period) else $error("on period not loaded");

    property p_off_period;
        conn_event && !pin_s.power_on |=> main_timer == OFF_SECONDS;
    endproperty
    a_off_period: assert property (p_off_period) else $error("off period not loaded");

    property p_fallback;
        pin_s.adaptor_detect_in && batt_code_valid && batt_code <= thr_normal && ctrl[`BCT_CTRL_FALLBACK]
        ##1 pin_s.adaptor_detect_in |=> !main_charge_mode_out;
    endproperty
    a_fallback: assert property (p_fallback) else $error("no fallback to normal");

    property p_abort;
        $fell(pin_s.adaptor_detect_in) |=> main_timer == '0 && main_charge_mode_out;
    endproperty
    a_abort: assert property (p_abort) else $error("period not aborted");

    property p_aux_trickle;
        aux_trickle_enable |-> $past(low5 && pin_s.adaptor_detect_in && pin_s.aux_backup_switch);
    endproperty
    a_aux_trickle: assert property (p_aux_trickle) else $error("aux trickle without low");

    property p_aux_normal;
        low_event && pin_s.aux_backup_switch ##1 pin_s.aux_backup_switch |=> !aux_charge_mode_out;
    endproperty
    a_aux_normal: assert property (p_aux_normal) else $error("aux normal not forced");

    property p_backup;
        low_event && pin_s.aux_backup_switch |=> backup_source_select;
    endproperty
    a_backup: assert property (p_backup) else $error("backup not selected");

    property p_switch_open;
        !pin_s.aux_backup_switch |=> aux_charge_mode_out && !backup_source_select && !aux_trickle_enable;
    endproperty
    a_switch_open: assert property (p_switch_open) else $error("aux active with switch open");

    property p_sample_off;
        sample_request && !pin_s.power_on |-> $past(sec_tick);
    endproperty
    a_sample_off: assert property (p_sample_off) else $error("sample off tick");
endmodule // bct_battery_charge_timer

// [core/bct_regs.svh]
`ifndef BCT_REGS_SVH
`define BCT_REGS_SVH
// Register byte offsets
`define BCT_CTRL_OFS        8'h00
`define BCT_THRESH_OFS      8'h04
`define BCT_STATUS_OFS      8'h08
`define BCT_TIMER_OFS       8'h0c
`define BCT_SAMPLE_OFS      8'h10
// Control fields
`define BCT_CTRL_BACKUP_CLR 0
`define BCT_CTRL_FALLBACK   1
`define BCT_CTRL_RESET      32'h0000_0002
// Threshold fields and reset codes (8-bit converter codes)
`define BCT_THR_NORMAL_LSB  0
`define BCT_THR_LOW_LSB     8
`define BCT_THR_NORMAL_CODE 8'he6
`define BCT_THR_LOW_CODE    8'hd9
// Timing
`define BCT_CLK_HZ          10000000
`define BCT_SEC_CYCLES      (`BCT_CLK_HZ)
`define BCT_NORMAL_ON_HOURS 11
`define BCT_NORMAL_OFF_HOURS 8
`define BCT_AUX_HOURS       8
`define BCT_SAMPLE_OFF_SEC  10
`define BCT_HOUR_SEC        3600
`define BCT_NORMAL_ON_SEC   (`BCT_NORMAL_ON_HOURS * `BCT_HOUR_SEC)
`define BCT_NORMAL_OFF_SEC  (`BCT_NORMAL_OFF_HOURS * `BCT_HOUR_SEC)
`define BCT_AUX_SEC         (`BCT_AUX_HOURS * `BCT_HOUR_SEC)
`endif

// [core/bct_pkg.sv]
package bct_pkg;
    // AXI4-Lite master to slave
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } bct_axi_req_type;
    // AXI4-Lite slave to master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } bct_axi_rsp_type;
    // Sampled pin group
    typedef struct packed {
        logic aux_backup_switch;
        logic charge_control_jumper;
        logic power_on;
        logic adaptor_detect_in;
    } bct_pins_type;
endpackage

// [testbench/bct_charger_model.sv]
`timescale 1ns/1ps
// Charger, adaptor sense and converter stand-in
module bct_charger_model
(
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Board state from the bench
    input  wire logic             adaptor,
    input  wire logic             power,
    input  wire logic             jumper,
    input  wire logic             aux_switch,
    input  wire logic [7:0]       level,
    input  wire logic [2:0]       lag,
    // Device side
    input  wire logic             sample_request,
    output bct_pkg::bct_pins_type pins,
    output logic      [7:0]       batt_code,
    output logic                  batt_code_valid
);
    import bct_pkg::*;
    logic [2:0] wait_cnt; // Conversion cycles left
    // Sense line high while adaptor feeds the charger
    assign pins = '{aux_switch, jumper, power, adaptor};
    // Converter answers each request after lag cycles
    always_ff @(posedge aclk)
    begin
        batt_code_valid <= 1'b0;
        batt_code       <= ~batt_code; // Stale code keeps moving
        if (!aresetn)
        begin
            wait_cnt  <= 3'h0;
            batt_code <= 8'h5a;
        end
        else if (sample_request)
            wait_cnt <= lag;
        else if (wait_cnt != 3'h0)
        begin
            wait_cnt <= wait_cnt - 3'h1;
            if (wait_cnt == 3'h1)
            begin
                batt_code_valid <= 1'b1;
                batt_code       <= level;
            end
        end
    end
endmodule // bct_charger_model

// [testbench/tb.sv]
`timescale 1ns/1ps
// Self-checking bench for the charge timer
module tb;
    import bct_pkg::*;
    localparam int   SEC  = 10; // Shortened second
    localparam int   ONS  = 6;  // Power-on period
    localparam int   OFFS = 4;  // Power-off period
    localparam int   AUXS = 5;  // Aux normal period
    logic            aclk, aresetn;                        // Clock, reset
    bct_axi_req_type axi_req;                              // Bus request
    bct_axi_rsp_type axi_rsp;                              // Bus answer
    bct_pins_type    pins;                                 // Board pins
    logic [7:0]      batt_code, level;                     // Code, battery level
    logic            batt_code_valid, sample_request;      // Converter handshake
    logic            adaptor, power, jumper, aux_switch;   // Board state
    logic [2:0]      lag;                                  // Converter delay
    logic            main_out, aux_out, aux_trickle, backup; // Controls
    logic [31:0]     rd;                                   // Read data
    logic [1:0]      resp;                                 // Bus response
    int              n_errors, n_compared, n_req;          // Counters
    // Clock
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // Count conversion requests
    always @(posedge aclk)
        if (sample_request === 1'b1)
            n_req++;
    bct_battery_charge_timer #(.SEC_CYCLES(SEC), .ON_SECONDS(16'(ONS)), .OFF_SECONDS(16'(OFFS)),
        .AUX_SECONDS(16'(AUXS))) u_bct_battery_charge_timer (.aclk(aclk), .aresetn(aresetn),
        .axi_req(axi_req), .axi_rsp(axi_rsp), .pins(pins), .batt_code(batt_code),
        .batt_code_valid(batt_code_valid), .sample_request(sample_request), .main_charge_mode_out(main_out),
        .aux_charge_mode_out(aux_out), .aux_trickle_enable(aux_trickle), .backup_source_select(backup));
    bct_charger_model u_bct_charger_model (.aclk(aclk), .aresetn(aresetn), .adaptor(adaptor),
        .power(power), .jumper(jumper), .aux_switch(aux_switch), .level(level), .lag(lag),
        .sample_request(sample_request), .pins(pins), .batt_code(batt_code),
        .batt_code_valid(batt_code_valid));
    // Normal period length in cycles
    function automatic int period(input logic pwr);
        return (pwr ? ONS : OFFS) * SEC;
    endfunction
    // Trickle above the normal-return code
    function automatic logic want_trickle(input logic [7:0] c);
        return c > 8'he6;
    endfunction
    // Random level above both thresholds
    function automatic logic [7:0] healthy();
        return 8'($urandom_range(255, 231));
    endfunction
    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Write, address and data offered together
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        aw = 1'b0;
        w = 1'b0;
        b = 1'b0;
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr  <= a;
        axi_req.wvalid  <= 1'b1;
        axi_req.wdata   <= d;
        axi_req.wstrb   <= 4'hf;
        axi_req.bready  <= 1'b1;
        while (!b)
        begin
            @(posedge aclk);
            if (!aw && axi_rsp.awready === 1'b1)
            begin
                aw = 1'b1;
                axi_req.awvalid <= 1'b0;
            end
            if (!w && axi_rsp.wready === 1'b1)
            begin
                w = 1'b1;
                axi_req.wvalid <= 1'b0;
            end
            if (axi_rsp.bvalid === 1'b1)
            begin
                b = 1'b1;
                resp = axi_rsp.bresp;
                axi_req.bready <= 1'b0;
            end
        end
    endtask
    // Read one word
    task automatic axi_read(input logic [7:0] a);
        logic ar, r;
        ar = 1'b0;
        r = 1'b0;
        axi_req.arvalid <= 1'b1;
        axi_req.araddr  <= a;
        axi_req.rready  <= 1'b1;
        while (!r)
        begin
            @(posedge aclk);
            if (!ar && axi_rsp.arready === 1'b1)
            begin
                ar = 1'b1;
                axi_req.arvalid <= 1'b0;
            end
            if (axi_rsp.rvalid === 1'b1)
            begin
                r = 1'b1;
                rd = axi_rsp.rdata;
                resp = axi_rsp.rresp;
                axi_req.rready <= 1'b0;
            end
        end
    endtask
    // Connect adaptor and time the normal period
    task automatic period_check(input logic pwr);
        power <= pwr;
        tick(6);
        adaptor <= 1'b1;
        tick(period(pwr) - 2);
        chk_bit(main_out, 1'b0);
        tick(16);
        chk_bit(main_out, want_trickle(level));
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        tick(5000);
        n_errors++;
        wrap_up();
    end
    // Main sequence
    initial
    begin
        axi_req = '0;
        {adaptor, power, jumper, aux_switch} = 4'h1;
        level = 8'hff;
        lag = 3'h2;
        aresetn = 1'b0;
        n_errors = 0;
        n_compared = 0;
        n_req = 0;
        void'($urandom(97997));
        tick(2);
        aresetn <= 1'b1;
        tick(1);
        chk_bit(main_out, 1'b1);
        chk_bit(aux_out, 1'b1);
        chk_bit(backup, 1'b0);
        chk_bit(aux_trickle, 1'b0);
        axi_read(8'h00);
        chk_word(rd, 32'h2);
        axi_read(8'h04);
        chk_word(rd, 32'h0000d9e6);
        axi_read(8'h10);
        chk_word(rd, 32'hff);
        axi_read(8'h14);
        chk_word({30'h0, resp}, 32'h2);
        axi_write(8'h20, 32'h1);
        chk_word({30'h0, resp}, 32'h2);
        level <= healthy();
        lag <= 3'($urandom_range(4, 1));
        period_check(1'b0);
        adaptor <= 1'b0;
        tick(10);
        chk_bit(main_out, 1'b1);
        period_check(1'b1);
        // Fallback from trickle at the normal-return code
        level <= 8'he6;
        tick(25);
        chk_bit(main_out, want_trickle(8'he6));
        chk_bit(aux_trickle, 1'b1);
        level <= 8'he7;
        tick(25);
        chk_bit(main_out, want_trickle(8'he7));
        chk_bit(aux_trickle, 1'b0);
        axi_read(8'h10);
        chk_word(rd, 32'he7);
        // Abort mid-period, then a fresh period
        adaptor <= 1'b0;
        tick(10);
        adaptor <= 1'b1;
        tick(20);
        adaptor <= 1'b0;
        tick(10);
        period_check(1'b0);
        jumper <= 1'b1;
        tick(100);
        chk_bit(main_out, 1'b0);
        axi_read(8'h08);
        chk_word(rd, 32'h0000002d);
        jumper <= 1'b0;
        tick(10);
        chk_bit(main_out, 1'b1);
        // Slow sampling while off
        n_req = 0;
        tick(250);
        chk_bit(n_req inside {[2:3]}, 1'b1);
        // Low voltage with switch closed
        power <= 1'b1;
        level <= 8'hd9;
        for (int i = 0; i < 30 && backup !== 1'b1; i++)
            @(posedge aclk);
        chk_bit(backup, 1'b1);
        level <= healthy();
        tick(2);
        chk_bit(aux_out, 1'b0);
        tick((AUXS - 1) * SEC - 1);
        chk_bit(aux_out, 1'b0);
        tick(10);
        chk_bit(aux_out, 1'b1);
        chk_bit(backup, 1'b1);
        axi_write(8'h00, 32'h3);
        tick(2);
        chk_bit(backup, 1'b0);
        axi_read(8'h00);
        chk_word(rd, 32'h2);
        // Open switch blocks backup and aux charge
        aux_switch <= 1'b0;
        tick(6);
        level <= 8'hd9;
        tick(25);
        chk_bit(backup, 1'b0);
        chk_bit(aux_out, 1'b1);
        axi_write(8'h04, 32'h0000c0e6);
        axi_read(8'h04);
        chk_word(rd, 32'h0000c0e6);
        wrap_up();
    end
endmodule // tb
